// ### design/ushift_top.sv
// Purpose: Four-stage universal shift register with an Avalon-MM register port.
// Assumes: Shift clock, controls, data and clear come from pins asynchronous to core_clk.
// Notes: Software may take over the controls and step the register itself.
// Summary of operation
// - The block holds four stages with serial and parallel entry and serial and parallel outputs.
// - Data enters only on the falling edge of the shift clock, or on a STEP write while software has the controls, never on the rising edge.
// - With load and shift both low the stages keep their contents at each falling edge.
// - With load high and shift low a falling edge copies the four parallel inputs into the stages.
// - With shift high a falling edge shifts the stages one place right, whatever load is.
// - Only the mode present at the falling edge acts, so mode changes never corrupt the stages.
// - The inverted value of the last stage is an output beside the true stage outputs.
// - The clear acts at once without a clock, and while it is low clock and controls do nothing.
// - Each stage is a D flip-flop whose input level at the active edge appears on its output.
`timescale 1ns/1ps
module ushift_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire ushift_pkg::pin_in_t pins,
    input wire logic clear_n,
    input wire logic [ushift_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ushift_pkg::AV_DATA_W-1:0] avs_writedata,
    input wire logic [ushift_pkg::AV_BE_W-1:0] avs_byteenable,
    output logic [ushift_pkg::AV_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [ushift_pkg::STAGES-1:0] stage_q,
    output logic last_n
);
    import ushift_pkg::*;

    function automatic logic hit(input logic [AV_ADDR_W-1:0] addr,
                                 input logic [AV_ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    // Pin synchronisers
    logic [PIN_W:0] sync_out;
    pin_in_t pins_s;
    logic clear_s_n;

    ushift_sync #(
        .W(PIN_W + 1)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({clear_n, pins}),
        .sync_out(sync_out)
    );

    assign clear_s_n = sync_out[PIN_W];
    assign pins_s = sync_out[PIN_W-1:0];

    // Falling edge of the synchronised shift clock
    logic clk_prev_q;
    logic pin_fall;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= pins_s.clk;
        end
    end

    assign pin_fall = clk_prev_q & ~pins_s.clk;

    // Avalon slave: one wait cycle, answer on the second edge
    logic ack_q;
    logic req;
    logic accept;
    logic [AV_DATA_W-1:0] rdata_q;
    ctrl_t ctrl_q;
    logic step_q;
    status_t status;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign accept = req & ack_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_comb begin
        status = '0;
        status.stages = stage_q;
        status.last_n = last_n;
        status.clr_act = ~clear_s_n;
        status.src_sw = ctrl_q.src_sw;
    end

    // Read data settles during the wait cycle and is held to the answer edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            if (hit(avs_address, REG_CTRL)) begin
                rdata_q <= ctrl_q;
            end else if (hit(avs_address, REG_STATUS)) begin
                rdata_q <= status;
            end else begin
                rdata_q <= RD_UNMAPPED;
            end
        end
    end

    assign avs_readdata = rdata_q;

    // Only lane 0 is live; upper bits stay zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else if (accept && avs_write && hit(avs_address, REG_CTRL)
                     && avs_byteenable[LANE_LIVE]) begin
            ctrl_q <= CTRL_RST;
            ctrl_q.src_sw <= avs_writedata[7];
            ctrl_q.sw_serial <= avs_writedata[6];
            ctrl_q.sw_shift <= avs_writedata[5];
            ctrl_q.sw_load <= avs_writedata[4];
            ctrl_q.sw_par <= avs_writedata[STAGES-1:0];
        end
    end

    // A write to STEP stands for one falling edge of the shift clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            step_q <= 1'b0;
        end else begin
            step_q <= accept & avs_write & hit(avs_address, REG_STEP)
                      & avs_byteenable[LANE_LIVE];
        end
    end

    // Source select; a clear in the synchroniser also inhibits the edge,
    // so a stale edge from before the clear cannot act after release
    mode_in_t mode;
    logic tick;

    always_comb begin
        if (ctrl_q.src_sw) begin
            mode.load = ctrl_q.sw_load;
            mode.shift = ctrl_q.sw_shift;
            mode.serial = ctrl_q.sw_serial;
            mode.par = ctrl_q.sw_par;
        end else begin
            mode.load = pins_s.load;
            mode.shift = pins_s.shift;
            mode.serial = pins_s.serial;
            mode.par = pins_s.par;
        end
    end

    assign tick = clear_s_n & (ctrl_q.src_sw ? step_q : pin_fall);

    ushift_core #(
        .N(STAGES)
    ) u_core (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clear_n(clear_n),
        .tick(tick),
        .mode(mode),
        .stages_q(stage_q),
        .last_n_q(last_n)
    );

    // Checks
    AST_HOLD_WHEN_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!tick && clear_n) ##1 clear_n |-> $stable(stage_q))
        else $error("Stages changed without a falling edge");

    AST_FALL_ONLY: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && !ctrl_q.src_sw) |-> ($past(pins_s.clk) && !pins_s.clk))
        else $error("Pin step taken on a non-falling edge");

    AST_STORE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && !mode.load && !mode.shift) ##1 clear_n |-> stage_q == $past(stage_q))
        else $error("Store mode altered the stages");

    AST_LOAD: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && mode.load && !mode.shift) ##1 clear_n |-> stage_q == $past(mode.par))
        else $error("Parallel load did not copy the inputs");

    AST_SHIFT: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && mode.shift) ##1 clear_n
        |-> stage_q == {$past(stage_q[STAGES-2:0]), $past(mode.serial)})
        else $error("Right shift gave the wrong stages");

    AST_SERIAL_ENTRY: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && mode.shift && mode.load) ##1 clear_n
        |-> stage_q[0] == $past(mode.serial))
        else $error("Serial input missed the first stage with load high");

    AST_LAST_INV: assert property (@(posedge core_clk) disable iff (sys_rst)
        last_n == ~stage_q[STAGES-1])
        else $error("Inverted last stage does not match");

    AST_CLEAR_INHIBIT: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!clear_n ##1 !clear_n) |-> (stage_q == '0 && last_n))
        else $error("Clear did not hold stages at zero");

    AST_D_CAPTURE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tick && mode.load && !mode.shift && clear_n) ##1 (!tick && clear_n) ##1 clear_n
        |-> stage_q == $past(mode.par, 2))
        else $error("Loaded value not kept after the edge");

    AST_BUS_ANSWER: assert property (@(posedge core_clk) disable iff (sys_rst)
        (req && !ack_q) |=> (req -> !avs_waitrequest))
        else $error("Bus answer later than one wait cycle");

    COV_LOAD: cover property (@(posedge core_clk) disable iff (sys_rst)
        tick && mode.load && !mode.shift);
    COV_SHIFT: cover property (@(posedge core_clk) disable iff (sys_rst)
        tick && mode.shift);
    COV_STORE: cover property (@(posedge core_clk) disable iff (sys_rst)
        tick && !mode.load && !mode.shift);
    COV_CLEAR: cover property (@(posedge core_clk) disable iff (sys_rst)
        !clear_n ##1 clear_n);

endmodule

// ### pkg/ushift_pkg.sv
// Purpose: Shared constants and carriers for the four-stage universal shift register.
// Assumes: Avalon-MM byte addresses, 32-bit data, one aligned word per register.
// Notes: Stage 0 is the first (serial-entry) stage, stage 3 the last.
package ushift_pkg;

    localparam int STAGES = 4;
    localparam int AV_ADDR_W = 4;
    localparam int AV_DATA_W = 32;
    localparam int AV_BE_W = 4;

    // Register byte offsets
    localparam logic [AV_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [AV_ADDR_W-1:0] REG_STEP = 4'h4;
    localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h8;

    // Only byte lane 0 holds live bits
    localparam int LANE_LIVE = 0;

    // Value returned for unmapped reads
    localparam logic [AV_DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;

    // Pins from the surrounding board logic, all asynchronous to core_clk
    typedef struct packed {
        logic clk;
        logic load;
        logic shift;
        logic serial;
        logic [STAGES-1:0] par;
    } pin_in_t;

    localparam int PIN_W = $bits(pin_in_t);

    // Control register: software may take over the pins
    typedef struct packed {
        logic [23:0] zero;
        logic src_sw;
        logic sw_serial;
        logic sw_shift;
        logic sw_load;
        logic [STAGES-1:0] sw_par;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = 32'h0000_0000;

    // Status register: live state of the stages
    typedef struct packed {
        logic [24:0] zero;
        logic src_sw;
        logic clr_act;
        logic last_n;
        logic [STAGES-1:0] stages;
    } status_t;

    // Mode inputs as seen at one falling clock edge
    typedef struct packed {
        logic load;
        logic shift;
        logic serial;
        logic [STAGES-1:0] par;
    } mode_in_t;

endpackage

// ### design/ushift_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Each bit is a slow level; no word coherence is promised across bits.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module ushift_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ### design/ushift_core.sv
// Purpose: The four D-type stages with hold, parallel load and right shift.
// Assumes: tick is a one-cycle pulse marking one falling edge of the shift clock.
// Notes: clear_n clears the stages at once, without any clock edge.
`timescale 1ns/1ps
module ushift_core #(
    parameter int N = ushift_pkg::STAGES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clear_n,
    input wire logic tick,
    input wire ushift_pkg::mode_in_t mode,
    output logic [N-1:0] stages_q,
    output logic last_n_q
);
    import ushift_pkg::*;

    logic [N-1:0] stages_d;

    // Shift wins over load; no tick means the stages keep their value
    always_comb begin
        stages_d = stages_q;
        if (tick) begin
            if (mode.shift) begin
                stages_d = {stages_q[N-2:0], mode.serial};
            end else if (mode.load) begin
                stages_d = mode.par;
            end
        end
    end

    // Clear is asynchronous and overrides everything while low
    always_ff @(posedge core_clk or negedge clear_n) begin
        if (!clear_n) begin
            stages_q <= '0;
        end else if (sys_rst) begin
            stages_q <= '0;
        end else begin
            stages_q <= stages_d;
        end
    end

    // Kept as its own flop so the inverted output is glitch free
    always_ff @(posedge core_clk or negedge clear_n) begin
        if (!clear_n) begin
            last_n_q <= 1'b1;
        end else if (sys_rst) begin
            last_n_q <= 1'b1;
        end else begin
            last_n_q <= ~stages_d[N-1];
        end
    end

    AST_CLEAR_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clear_n |-> (stages_q == '0 && last_n_q))
        else $error("Stages not zero while clear is low");

endmodule

// ### bench/ushift_board.sv
// Purpose: Board logic that drives the shift clock, the controls and the data pins.
// Assumes: Called just after a core_clk rising edge; changes pins by non-blocking assignment.
// Notes: Clock levels are held six cycles and control levels three, so the two-flop synchroniser sees each.
`timescale 1ns/1ps
module ushift_board (
    input wire logic core_clk,
    output ushift_pkg::pin_in_t pins
);
    import ushift_pkg::*;

    initial begin
        pins = '0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Controls settle well ahead of any fall so no mode is half seen
    task automatic set_mode(input logic ld, input logic sh, input logic ser,
                            input logic [STAGES-1:0] par);
        @(posedge core_clk);
        pins.load <= ld;
        pins.shift <= sh;
        pins.serial <= ser;
        pins.par <= par;
        wait_clk(3);
    endtask

    task automatic clk_to(input logic v);
        @(posedge core_clk);
        pins.clk <= v;
        wait_clk(6);
    endtask
endmodule

// ### bench/ushift_top_tb.sv
// Purpose: Self-checking bench for the shift register, pin and register paths.
// Assumes: One wait cycle per bus access; pin steps land three edges after the pin is driven.
// Notes: Expected stage values are kept in exp and advanced by hand.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module ushift_top_tb;
    import ushift_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear_n = 1'b1;
    pin_in_t pins;
    logic [AV_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [AV_DATA_W-1:0] avs_writedata = '0;
    logic [AV_BE_W-1:0] avs_byteenable = 4'h1;
    logic [AV_DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [STAGES-1:0] stage_q;
    logic last_n;
    logic [AV_DATA_W-1:0] rd;
    logic [STAGES-1:0] exp;
    int n_mismatch = 0;
    int compares = 0;

    ushift_board i_board (.core_clk(core_clk), .pins(pins));
    ushift_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .pins(pins), .clear_n(clear_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stage_q(stage_q), .last_n(last_n));

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Request held until waitrequest is seen low, then taken at that edge
    task automatic av(input logic wr, input logic [AV_ADDR_W-1:0] a,
                      input logic [AV_DATA_W-1:0] d);
        int i;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // Waitrequest and read data are sampled at the rising edge only
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_mismatch++;
            print_verdict();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic pulse();
        i_board.clk_to(1'b1);
        i_board.clk_to(1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        int k;
        logic [1:0] md [4] = '{2'b11, 2'b00, 2'b10, 2'b01};
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("stage", 4'h0, stage_q)
        av(1'b0, REG_STATUS, '0);
        `CHK("status", 32'h10, rd)
        av(1'b1, 4'hc, 32'hff);
        av(1'b0, 4'hc, '0);
        `CHK("unmapped", RD_UNMAPPED, rd)
        av(1'b0, REG_CTRL, '0);
        `CHK("ctrl", 32'h0, rd)
        // A write with lane 0 disabled must leave the control register alone
        avs_byteenable <= 4'h0;
        av(1'b1, REG_CTRL, 32'h93);
        avs_byteenable <= 4'h1;
        av(1'b0, REG_CTRL, '0);
        `CHK("ctrl_lane_off", 32'h0, rd)
        i_board.set_mode(1'b1, 1'b0, 1'b0, 4'ha);
        i_board.clk_to(1'b1);
        `CHK("rise", 4'h0, stage_q)
        i_board.clk_to(1'b0);
        `CHK("load", 4'ha, stage_q)
        `CHK("last_n", 1'b0, last_n)
        exp = 4'ha;
        i_board.set_mode(1'b0, 1'b0, 1'b1, 4'h5);
        pulse();
        `CHK("hold", exp, stage_q)
        for (k = 0; k < 4; k++) begin
            i_board.set_mode(md[k][1], 1'b1, md[k][0], ~exp);
            pulse();
            exp = {exp[STAGES-2:0], md[k][0]};
            `CHK("shift", exp, stage_q)
            `CHK("last_n", ~exp[STAGES-1], last_n)
        end
        // Mode churn while the clock is high must leave no trace
        i_board.clk_to(1'b1);
        i_board.set_mode(1'b1, 1'b0, 1'b0, 4'hf);
        i_board.set_mode(1'b0, 1'b1, 1'b1, 4'h0);
        i_board.set_mode(1'b0, 1'b0, 1'b0, 4'h0);
        i_board.clk_to(1'b0);
        `CHK("churn", exp, stage_q)
        i_board.set_mode(1'b1, 1'b0, 1'b0, 4'hf);
        @(posedge core_clk);
        clear_n <= 1'b0;
        #1;
        `CHK("clear", 4'h0, stage_q)
        pulse();
        `CHK("clear_hold", 4'h0, stage_q)
        `CHK("clear_last_n", 1'b1, last_n)
        av(1'b0, REG_STATUS, '0);
        `CHK("status_clr", 32'h30, rd)
        @(posedge core_clk);
        clear_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        `CHK("released", 4'h0, stage_q)
        pulse();
        `CHK("reload", 4'hf, stage_q)
        av(1'b1, REG_CTRL, 32'h93);
        av(1'b1, REG_STEP, 32'h1);
        repeat (4) @(posedge core_clk);
        `CHK("sw_load", 4'h3, stage_q)
        i_board.set_mode(1'b0, 1'b1, 1'b0, 4'h0);
        pulse();
        `CHK("pins_off", 4'h3, stage_q)
        av(1'b0, REG_STATUS, '0);
        `CHK("status_sw", 32'h53, rd)
        av(1'b1, REG_CTRL, 32'he0);
        av(1'b1, REG_STEP, 32'h1);
        repeat (4) @(posedge core_clk);
        `CHK("sw_shift", 4'h7, stage_q)
        av(1'b1, REG_CTRL, 32'h0);
        av(1'b0, REG_CTRL, '0);
        `CHK("ctrl_back", 32'h0, rd)
        print_verdict();
    end
endmodule
